// ---- pss_params.svh ----
// Constants for the PLL output stop and programming select block.
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Configuration bit positions
// ----------------------------------------------------------------------------
`define PSS_CFG_WIDTH 64
`define PSS_BIT_PLL_OFF 57
`define PSS_BIT_STOP_LEVEL 58
`define PSS_BIT_STOP_GATED 59

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PSS_TDO_RESET 1'b0
`define PSS_STOP_LEVEL_RESET 1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PSS_CLK_PERIOD_NS 100
`define PSS_IR_LEN 4

`endif

// ---- pss_pkg.sv ----
// Types for the PLL output stop and programming select block.
package pss_pkg;

	// ------------------------------------------------------------------------
	// TAP controller states
	// ------------------------------------------------------------------------
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
		TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
		TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
	} pss_tap_state_t;

	// ------------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] bank_outputs;
		logic feedback_out_true;
		logic feedback_out_comp;
	} pss_clk_out_t;

	typedef struct packed {
		logic [1:0] strap_hi;
		logic [1:0] strap_lo;
	} pss_i2c_addr_t;

endpackage : pss_pkg

// ---- pss_ctrl.sv ----
// Output stop, PLL bypass, lock flag and serial port select control.
`timescale 1ns/1ns
`include "pss_params.svh"

// Summary of operation
// - Bypass pin or bit 57 routes reference out.
// - PLL active only when both cleared.
// - Power-down low halts inputs and switching.
// - Mode pin low, bit59 low: tri-state.
// - Mode pin or bit59 high: gated stop.
// - Bit 58 picks stopped levels, feedback complement inverted.
// - Lock flag high only when PLL locked.
// - Select high JTAG; low I2C, TAP reset.
// - Test reset low resets JTAG logic.
// - Serial out changes on falling edge, else off.
// - TAP samples TMS on rising test clock.
// - TDI captured on rising test clock.
// - Three-level straps set I2C address.
module pss_ctrl #(
	parameter int CFG_WIDTH = `PSS_CFG_WIDTH,
	parameter int IR_LEN = `PSS_IR_LEN
) (
	// Clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	// Control pins
	input wire logic I_PLL_BYPASS,
	input wire logic I_POWER_DOWN_N,
	input wire logic I_STOP_MODE_PIN,
	input wire logic I_BANK_OUTPUT_ENABLE_N,
	input wire logic [CFG_WIDTH-1:0] I_CFG,
	// Clock path
	input wire logic I_REF_CLK,
	input wire logic I_PLL_CLK,
	input wire logic I_PLL_LOCKED,
	// Serial port
	input wire logic I_IF_SELECT,
	input wire logic I_TEST_RESET_N,
	input wire logic I_TEST_CLOCK,
	input wire logic I_TMS,
	input wire logic I_TDI,
	input wire logic [1:0] I_I2C_ADDR_STRAP_HI,
	input wire logic [1:0] I_I2C_ADDR_STRAP_LO,
	// Outputs
	output pss_pkg::pss_clk_out_t O_CLK,
	output logic O_CLK_OE,
	output logic O_PLL_ENABLE,
	output logic O_LOCK,
	output logic O_TDO,
	output logic O_TDO_OE,
	output logic O_JTAG_ACTIVE,
	output pss_pkg::pss_i2c_addr_t O_I2C_ADDR
);

	// ------------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------------
	if (CFG_WIDTH <= `PSS_BIT_STOP_GATED) begin : g_bad_cfg
		$error("Configuration word too narrow for stop bits.");
	end
	if (IR_LEN < 2) begin : g_bad_ir
		$error("Instruction register must hold at least two bits.");
	end

	// ------------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------------
	localparam int NS = 16;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s1_d;
	logic [NS-1:0] s2_d;
	assign raw_in = {I_PLL_BYPASS, I_POWER_DOWN_N, I_STOP_MODE_PIN, I_BANK_OUTPUT_ENABLE_N,
		I_REF_CLK, I_PLL_CLK, I_PLL_LOCKED, I_IF_SELECT, I_TEST_RESET_N, I_TEST_CLOCK,
		I_TMS, I_TDI, I_I2C_ADDR_STRAP_HI, I_I2C_ADDR_STRAP_LO};

	always_comb begin
		s1_d = raw_in;
		s2_d = s1_q;
	end

	always_ff @(posedge I_CORE_CLK) begin
		s1_q <= s1_d;
		s2_q <= s2_d;
	end

	logic bypass_s, pd_n_s, mode_s, oe_n_s, ref_s, pllc_s, lock_s;
	logic sel_s, trst_n_s, tck_s, tms_s, tdi_s;
	logic [1:0] ahi_s, alo_s;
	assign {bypass_s, pd_n_s, mode_s, oe_n_s, ref_s, pllc_s, lock_s,
		sel_s, trst_n_s, tck_s, tms_s, tdi_s, ahi_s, alo_s} = s2_q;

	// ------------------------------------------------------------------------
	// Output clock path and stop control
	// ------------------------------------------------------------------------
	logic pll_off;
	logic stop_gated;
	logic stop_level;
	logic src_clk;
	assign pll_off = bypass_s | I_CFG[`PSS_BIT_PLL_OFF];
	assign stop_gated = mode_s | I_CFG[`PSS_BIT_STOP_GATED];
	assign stop_level = I_CFG[`PSS_BIT_STOP_LEVEL];
	assign src_clk = pll_off ? ref_s : pllc_s;

	logic src_prev_q, src_prev_d;
	logic stopped_q, stopped_d;
	pss_pkg::pss_clk_out_t clk_q, clk_d;
	logic clk_oe_q, clk_oe_d;
	logic pll_en_q, pll_en_d;
	logic lock_q, lock_d;
	logic want_stop;
	logic at_boundary;
	logic lvl;

	assign want_stop = oe_n_s | ~pd_n_s;
	assign lvl = ~stop_level;
	// A falling edge of the output leaves it low, so the stop level is reached
	// without a truncated high pulse.
	assign at_boundary = src_prev_q & ~src_clk;

	always_comb begin
		src_prev_d = pd_n_s ? src_clk : src_prev_q;
		stopped_d = stopped_q;
		if (want_stop != stopped_q && (at_boundary || !pd_n_s)) begin
			stopped_d = want_stop;
		end
		clk_d = clk_q;
		clk_oe_d = 1'b1;
		if (stopped_d) begin
			if (stop_gated) begin
				clk_d.bank_outputs = {2{lvl}};
				clk_d.feedback_out_true = lvl;
				clk_d.feedback_out_comp = ~lvl;
			end else begin
				clk_oe_d = 1'b0;
			end
		end else if (pd_n_s) begin
			clk_d.bank_outputs = {2{src_clk}};
			clk_d.feedback_out_true = src_clk;
			clk_d.feedback_out_comp = ~src_clk;
		end
		pll_en_d = ~pll_off & pd_n_s;
		lock_d = lock_s & ~pll_off & pd_n_s;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			src_prev_q <= 1'b0;
			stopped_q <= 1'b1;
			clk_q <= '0;
			clk_oe_q <= 1'b0;
			pll_en_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			src_prev_q <= src_prev_d;
			stopped_q <= stopped_d;
			clk_q <= clk_d;
			clk_oe_q <= clk_oe_d;
			pll_en_q <= pll_en_d;
			lock_q <= lock_d;
		end
	end

	// ------------------------------------------------------------------------
	// TAP controller on sampled test clock edges
	// ------------------------------------------------------------------------
	logic tck_prev_q, tck_prev_d;
	logic tck_rise, tck_fall;
	logic tap_force;
	pss_pkg::pss_tap_state_t tap_q, tap_d;
	logic [IR_LEN-1:0] ir_q, ir_d;
	logic dr_q, dr_d;
	logic tdo_q, tdo_d;
	logic tdo_oe_q, tdo_oe_d;
	logic jtag_q, jtag_d;
	pss_pkg::pss_i2c_addr_t addr_q, addr_d;

	assign tck_rise = tck_s & ~tck_prev_q;
	assign tck_fall = ~tck_s & tck_prev_q;
	// Test reset and interface select act without waiting for a test clock edge.
	assign tap_force = ~trst_n_s | ~sel_s;

	always_comb begin
		tck_prev_d = tck_s;
		tap_d = tap_q;
		ir_d = ir_q;
		dr_d = dr_q;
		tdo_d = tdo_q;
		tdo_oe_d = tdo_oe_q;
		jtag_d = sel_s;
		addr_d = addr_q;
		if (tap_force) begin
			tap_d = pss_pkg::TAP_RESET;
			tdo_oe_d = 1'b0;
		end else if (tck_rise) begin
			case (tap_q)
				pss_pkg::TAP_RESET: tap_d = tms_s ? pss_pkg::TAP_RESET : pss_pkg::TAP_IDLE;
				pss_pkg::TAP_IDLE: tap_d = tms_s ? pss_pkg::TAP_SEL_DR : pss_pkg::TAP_IDLE;
				pss_pkg::TAP_SEL_DR: tap_d = tms_s ? pss_pkg::TAP_SEL_IR : pss_pkg::TAP_CAP_DR;
				pss_pkg::TAP_CAP_DR: tap_d = tms_s ? pss_pkg::TAP_EXIT1_DR : pss_pkg::TAP_SHIFT_DR;
				pss_pkg::TAP_SHIFT_DR: tap_d = tms_s ? pss_pkg::TAP_EXIT1_DR : pss_pkg::TAP_SHIFT_DR;
				pss_pkg::TAP_EXIT1_DR: tap_d = tms_s ? pss_pkg::TAP_UPD_DR : pss_pkg::TAP_PAUSE_DR;
				pss_pkg::TAP_PAUSE_DR: tap_d = tms_s ? pss_pkg::TAP_EXIT2_DR : pss_pkg::TAP_PAUSE_DR;
				pss_pkg::TAP_EXIT2_DR: tap_d = tms_s ? pss_pkg::TAP_UPD_DR : pss_pkg::TAP_SHIFT_DR;
				pss_pkg::TAP_UPD_DR: tap_d = tms_s ? pss_pkg::TAP_SEL_DR : pss_pkg::TAP_IDLE;
				pss_pkg::TAP_SEL_IR: tap_d = tms_s ? pss_pkg::TAP_RESET : pss_pkg::TAP_CAP_IR;
				pss_pkg::TAP_CAP_IR: tap_d = tms_s ? pss_pkg::TAP_EXIT1_IR : pss_pkg::TAP_SHIFT_IR;
				pss_pkg::TAP_SHIFT_IR: tap_d = tms_s ? pss_pkg::TAP_EXIT1_IR : pss_pkg::TAP_SHIFT_IR;
				pss_pkg::TAP_EXIT1_IR: tap_d = tms_s ? pss_pkg::TAP_UPD_IR : pss_pkg::TAP_PAUSE_IR;
				pss_pkg::TAP_PAUSE_IR: tap_d = tms_s ? pss_pkg::TAP_EXIT2_IR : pss_pkg::TAP_PAUSE_IR;
				pss_pkg::TAP_EXIT2_IR: tap_d = tms_s ? pss_pkg::TAP_UPD_IR : pss_pkg::TAP_SHIFT_IR;
				default: tap_d = tms_s ? pss_pkg::TAP_SEL_DR : pss_pkg::TAP_IDLE;
			endcase
			if (tap_q == pss_pkg::TAP_SHIFT_IR) begin
				ir_d = {tdi_s, ir_q[IR_LEN-1:1]};
			end else if (tap_q == pss_pkg::TAP_CAP_IR) begin
				ir_d = {{(IR_LEN-1){1'b0}}, 1'b1};
			end
			if (tap_q == pss_pkg::TAP_SHIFT_DR) begin
				dr_d = tdi_s;
			end
		end else if (tck_fall) begin
			if (tap_q == pss_pkg::TAP_SHIFT_IR) begin
				tdo_d = ir_q[0];
				tdo_oe_d = 1'b1;
			end else if (tap_q == pss_pkg::TAP_SHIFT_DR) begin
				tdo_d = dr_q;
				tdo_oe_d = 1'b1;
			end else begin
				tdo_oe_d = 1'b0;
			end
		end
		if (!sel_s) begin
			// Straps share the serial pins, so they are only taken while select is low.
			addr_d.strap_hi = ahi_s;
			addr_d.strap_lo = alo_s;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			tck_prev_q <= 1'b0;
			tap_q <= pss_pkg::TAP_RESET;
			ir_q <= '0;
			dr_q <= 1'b0;
			tdo_q <= `PSS_TDO_RESET;
			tdo_oe_q <= 1'b0;
			jtag_q <= 1'b0;
			addr_q <= '0;
		end else begin
			tck_prev_q <= tck_prev_d;
			tap_q <= tap_d;
			ir_q <= ir_d;
			dr_q <= dr_d;
			tdo_q <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
			jtag_q <= jtag_d;
			addr_q <= addr_d;
		end
	end

	assign O_CLK = clk_q;
	assign O_CLK_OE = clk_oe_q;
	assign O_PLL_ENABLE = pll_en_q;
	assign O_LOCK = lock_q;
	assign O_TDO = tdo_q;
	assign O_TDO_OE = tdo_oe_q;
	assign O_JTAG_ACTIVE = jtag_q;
	assign O_I2C_ADDR = addr_q;

endmodule : pss_ctrl

// ---- pss_ctrl_chk.sv ----
// Concurrent checks on the stop, bypass, lock and port select control.
`timescale 1ns/1ns
module pss_ctrl_chk #(
	parameter int CFG_WIDTH = 64
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic I_PLL_BYPASS,
	input wire logic I_POWER_DOWN_N,
	input wire logic I_STOP_MODE_PIN,
	input wire logic [CFG_WIDTH-1:0] I_CFG,
	input wire logic I_PLL_LOCKED,
	input wire logic I_IF_SELECT,
	input wire logic I_TEST_RESET_N,
	input wire logic I_TEST_CLOCK,
	input wire pss_pkg::pss_clk_out_t O_CLK,
	input wire logic O_CLK_OE,
	input wire logic O_PLL_ENABLE,
	input wire logic O_LOCK,
	input wire logic O_TDO,
	input wire logic O_TDO_OE,
	input wire logic O_JTAG_ACTIVE
);
	// ------------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------------
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	sequence s_i2c_held;
		(!I_IF_SELECT) [*3];
	endsequence
	sequence s_gated_held;
		(!I_POWER_DOWN_N && I_STOP_MODE_PIN) [*4];
	endsequence
	sequence s_src_steady;
		(I_POWER_DOWN_N && !I_PLL_BYPASS && !I_CFG[57]) [*4];
	endsequence
	property p_byp_off;
		I_PLL_BYPASS [*3] |=> !O_PLL_ENABLE;
	endproperty
	property p_cfg_off;
		I_CFG[57] |=> !O_PLL_ENABLE;
	endproperty
	property p_pll_on;
		(!I_PLL_BYPASS && !I_CFG[57] && I_POWER_DOWN_N) [*4] |=> O_PLL_ENABLE;
	endproperty
	property p_lock_off;
		(!I_PLL_LOCKED) [*3] |=> !O_LOCK;
	endproperty
	property p_tristate;
		(!I_POWER_DOWN_N && !I_STOP_MODE_PIN && !I_CFG[59]) [*4] |=> !O_CLK_OE;
	endproperty
	property p_gated;
		// The level bit is the one seen on the edge that wrote the outputs.
		s_gated_held |=> O_CLK_OE && O_CLK == ($past(I_CFG[58]) ? 4'h1 : 4'hE);
	endproperty
	property p_i2c_sel;
		s_i2c_held |=> !O_JTAG_ACTIVE && !O_TDO_OE;
	endproperty
	property p_trst;
		(!I_TEST_RESET_N) [*3] |=> !O_TDO_OE;
	endproperty
	property p_tdo_fall;
		O_TDO_OE && $changed(O_TDO) |-> !$past(I_TEST_CLOCK, 2);
	endproperty
	property p_no_runt;
		s_src_steady ##0 $rose(O_CLK.bank_outputs[0]) |=> O_CLK.bank_outputs[0];
	endproperty
	a_byp_off: assert property (p_byp_off)
		else $error("PLL left running with bypass pin high");
	a_cfg_off: assert property (p_cfg_off)
		else $error("PLL left running with its stored off bit set");
	a_pll_on: assert property (p_pll_on)
		else $error("PLL not running with both controls cleared");
	a_lock_off: assert property (p_lock_off)
		else $error("Lock flag high while loop unlocked");
	a_tristate: assert property (p_tristate)
		else $error("Stopped outputs still driven in tri-state mode");
	a_gated: assert property (p_gated)
		else $error("Gated stop levels wrong");
	a_i2c_sel: assert property (p_i2c_sel)
		else $error("Serial port not released in I2C mode");
	a_trst: assert property (p_trst)
		else $error("Serial out driven during test reset");
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("Serial out moved while test clock high");
	a_no_runt: assert property (p_no_runt)
		else $error("Output clock high for a single cycle");
endmodule : pss_ctrl_chk

bind pss_ctrl pss_ctrl_chk #(.CFG_WIDTH(CFG_WIDTH)) u_pss_ctrl_chk (
	.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PLL_BYPASS(I_PLL_BYPASS),
	.I_POWER_DOWN_N(I_POWER_DOWN_N), .I_STOP_MODE_PIN(I_STOP_MODE_PIN), .I_CFG(I_CFG),
	.I_PLL_LOCKED(I_PLL_LOCKED), .I_IF_SELECT(I_IF_SELECT), .I_TEST_RESET_N(I_TEST_RESET_N),
	.I_TEST_CLOCK(I_TEST_CLOCK), .O_CLK(O_CLK), .O_CLK_OE(O_CLK_OE),
	.O_PLL_ENABLE(O_PLL_ENABLE), .O_LOCK(O_LOCK), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
	.O_JTAG_ACTIVE(O_JTAG_ACTIVE));

// ---- pss_host_model.sv ----
// Host side of the serial programming port, driving the JTAG pins.
`timescale 1ns/1ns
module pss_host_model (
	// Clock
	input wire logic i_clk,
	// Serial pins
	output logic o_test_clock = 1'b0,
	output logic o_tms = 1'b1,
	output logic o_tdi = 1'b0,
	output logic o_test_reset_n = 1'b0,
	// Sample strobe, high just after each rising test clock
	output logic o_smp = 1'b0
);
	// ------------------------------------------------------------------------
	// Bit cycle of eight core cycles
	// ------------------------------------------------------------------------
	// TMS and TDI move only while the test clock is low, well ahead of its rise.
	task bit_cyc(input logic tms, input logic tdi);
		@(posedge i_clk);
		o_test_clock <= 1'b0;
		o_tms <= tms;
		o_tdi <= tdi;
		repeat (4) @(posedge i_clk);
		o_test_clock <= 1'b1;
		o_smp <= 1'b1;
		@(posedge i_clk);
		o_smp <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : bit_cyc

	task trst(input logic v);
		@(posedge i_clk);
		o_test_reset_n <= v;
	endtask : trst
endmodule : pss_host_model

// ---- tb_top.sv ----
// Self-checking bench for the stop, bypass, lock and port select control.
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0, rst = 1'b1, byp = 1'b0, pd_n = 1'b1, mode = 1'b0, oe_n = 1'b0;
	logic lkd = 1'b1, sel = 1'b0, look = 1'b0;
	logic [63:0] cfg = '0;
	logic [1:0] s_hi = 2'h0, s_lo = 2'h0, h, l;
	logic [2:0] div = 3'h0;
	logic [8:0] walk = 9'h05F;
	logic tck, tms, tdi, trst_n, smp, clk_oe, pll_en, lock, tdo, tdo_oe, jact;
	logic [7:0] d, e8;
	pss_pkg::pss_clk_out_t clk_o;
	pss_pkg::pss_i2c_addr_t addr;
	logic [3:0][5:0] obs;
	logic [7:0] q_lvl [$];
	logic [1:0] q_tdo [$];
	int error_cnt = 0;
	int cmp_count = 0;
	assign obs = {{4'h0, jact, clk_oe}, {2'h0, addr}, {1'b0, clk_oe, clk_o}, {4'h0, pll_en, lock}};
	initial begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk) div <= div + 3'h1;
	pss_ctrl u_pss_ctrl (.I_CORE_CLK(clk), .I_RST(rst), .I_PLL_BYPASS(byp),
		.I_POWER_DOWN_N(pd_n), .I_STOP_MODE_PIN(mode), .I_BANK_OUTPUT_ENABLE_N(oe_n),
		.I_CFG(cfg), .I_REF_CLK(div[2]), .I_PLL_CLK(~div[2]), .I_PLL_LOCKED(lkd),
		.I_IF_SELECT(sel), .I_TEST_RESET_N(trst_n), .I_TEST_CLOCK(tck), .I_TMS(tms),
		.I_TDI(tdi), .I_I2C_ADDR_STRAP_HI(s_hi), .I_I2C_ADDR_STRAP_LO(s_lo), .O_CLK(clk_o),
		.O_CLK_OE(clk_oe), .O_PLL_ENABLE(pll_en), .O_LOCK(lock), .O_TDO(tdo),
		.O_TDO_OE(tdo_oe), .O_JTAG_ACTIVE(jact), .O_I2C_ADDR(addr));
	pss_host_model u_pss_host_model (.i_clk(clk), .o_test_clock(tck), .o_tms(tms),
		.o_tdi(tdi), .o_test_reset_n(trst_n), .o_smp(smp));
	// ------------------------------------------------------------------------
	// Notes, comparisons and verdict
	// ------------------------------------------------------------------------
	task note(input logic [1:0] k, input logic [5:0] v);
		q_lvl.push_back({k, v});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
		@(posedge clk);
	endtask : note
	task cmp_lvl(input logic [5:0] e, input logic [5:0] a);
		cmp_count++;
		if (a !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask : cmp_lvl
	task cmp_tdo(input logic [1:0] e, input logic [1:0] a);
		cmp_lvl({4'h0, e}, {4'h0, a});
	endtask : cmp_tdo
	task tally_and_finish;
		$display("compares=%0d errors=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		if (look) begin
			e8 = q_lvl.pop_front();
			cmp_lvl(e8[5:0], obs[e8[7:6]]);
		end
		if (smp && q_tdo.size() > 0) cmp_tdo(q_tdo.pop_front(), {tdo_oe, tdo});
	end
	initial begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(35));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			byp <= i[0];
			cfg[57] <= i[1];
			lkd <= (i != 0);
			repeat (6) @(posedge clk);
			note(2'h0, {4'h0, ~|i[1:0], ~|i[1:0] & (i != 0)});
		end
		for (int i = 0; i < 8; i++) begin
			mode <= i[0];
			cfg[59] <= i[1];
			cfg[58] <= i[2];
			pd_n <= 1'b0;
			oe_n <= 1'b1;
			repeat (12) @(posedge clk);
			if (i[0] | i[1]) note(2'h1, {2'h1, i[2] ? 4'h1 : 4'hE});
			else note(2'h3, 6'h00);
		end
		pd_n <= 1'b1;
		oe_n <= 1'b0;
		repeat (16) @(posedge clk);
		note(2'h3, 6'h01);
		// Stop with power up: entry and exit must wait for a falling output edge.
		oe_n <= 1'b1;
		repeat (16) @(posedge clk);
		note(2'h1, 6'h11);
		oe_n <= 1'b0;
		repeat (16) @(posedge clk);
		note(2'h3, 6'h01);
		for (int i = 0; i < 3; i++) begin
			h = 2'($urandom % 3);
			l = 2'($urandom % 3);
			s_hi <= h;
			s_lo <= l;
			repeat (6) @(posedge clk);
			note(2'h2, {2'h0, h, l});
		end
		sel <= 1'b1;
		u_pss_host_model.trst(1'b1);
		repeat (4) @(posedge clk);
		note(2'h3, 6'h03);
		for (int k = 0; k < 9; k++) u_pss_host_model.bit_cyc(walk[k], 1'b0);
		d = 8'($urandom);
		for (int i = 0; i < 8; i++) begin
			if (i > 0) q_tdo.push_back({1'b1, d[i-1]});
			u_pss_host_model.bit_cyc(1'b0, d[i]);
		end
		sel <= 1'b0;
		repeat (8) @(posedge clk);
		tally_and_finish;
	end
endmodule : tb_top
